/* inc/ext_bus_pkg.sv */
// Function
// - Any external access switches pins to bus
// - Disable from external code waits for internal branch
// - Idle internal: float AD/A, strobes high, latch/byte low
// - AD low, AD high, A19:16, control byte ports
// - Only 16-bit data path, not software changeable
// - Latch strobe with address, then output enable
// - Chip select on access, high in sleep
// - Byte write: latch both halves, strobe by bit 0
// - Word write even: hold byte, float, no strobe
// - Word write odd: latch high, held byte low
// - Word write: bit 0 out, both selects, high strobe only if odd
// - Byte select: both halves, high strobe, select byte
// - Mode field: 1x word, 01 select, 00 byte
// - Wait field: 11->0, 10->1, 01->2, 00->3 cycles
// - Disable clear means bus, set means I/O
package ext_bus_pkg;
	localparam int          ADDR_W      = 20;
	localparam int          DATA_W      = 16;
	localparam logic [1:0]  WM_BYTE_WR  = 2'h0;
	localparam logic [1:0]  WM_BYTE_SEL = 2'h1;
	localparam int          WM_WORD_BIT = 1;
	localparam logic [7:0]  CTL_IDLE    = 8'hee;
	localparam int          CTL_ALE     = 0;
	localparam int          CTL_OE      = 1;
	localparam int          CTL_WRL     = 2;
	localparam int          CTL_WRH     = 3;
	localparam int          CTL_BA0     = 4;
	localparam int          CTL_CE      = 5;
	localparam int          CTL_LB      = 6;
	localparam int          CTL_UB      = 7;
	localparam logic [1:0]  WAIT_MAX    = 2'h3;

	typedef enum logic [1:0] {
		WR_BYTE_type_unused, WR_MODE_DUMMY, WR_MODE_DUMMY2, WR_MODE_DUMMY3
	} unused_type;

	typedef enum {
		ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT
	} bus_state_type;

	// Extra wait cycles from the wait field
	function automatic logic [1:0] wait_cycles(input logic [1:0] field);
		wait_cycles = WAIT_MAX - field;
	endfunction : wait_cycles
endpackage : ext_bus_pkg

/* inc/pin_mux_if.sv */
// Bus-side pin values handed from the sequencer to the pin mux
interface pin_mux_if;
	import ext_bus_pkg::*;
	logic                bus_own;
	logic [DATA_W-1:0]   ad_out;
	logic                ad_oe;
	logic [3:0]          a_hi;
	logic [7:0]          ctl;

	modport src (output bus_own, output ad_out, output ad_oe,
		output a_hi, output ctl);
	modport dst (input bus_own, input ad_out, input ad_oe,
		input a_hi, input ctl);
endinterface : pin_mux_if

/* rtl/ext_pin_mux.sv */
// Registered pin multiplexer between bus function and general ports
module ext_pin_mux
	import ext_bus_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Bus side
	pin_mux_if.dst                 bus,
	// General port side
	input  wire logic [27:0]       port_out,
	input  wire logic [27:0]       port_oe,
	// Pins
	output logic      [27:0]       pin_out,
	output logic      [27:0]       pin_oe
);
	logic [27:0] bus_val;
	logic [27:0] bus_en;

	// Pin order: AD7:0, AD15:8, A19:16, control byte
	always_comb begin
		bus_val = {bus.ctl, bus.a_hi, bus.ad_out};
		// Upper address floats unless a cycle holds chip select
		bus_en  = {8'hff, {4{!bus.ctl[CTL_CE]}}, {DATA_W{bus.ad_oe}}};
	end

	// Port logic regains every pin when the bus lets go
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out <= 28'h0000000;
			pin_oe  <= 28'h0000000;
		end else if (bus.bus_own) begin
			pin_out <= bus_val;
			pin_oe  <= bus_en;
		end else begin
			pin_out <= port_out;
			pin_oe  <= port_oe;
		end
	end
endmodule : ext_pin_mux

/* rtl/ext_memory_bus_16bit.sv */
// Multiplexed 16-bit external memory bus sequencer
module ext_memory_bus_16bit
	import ext_bus_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	// Configuration
	input  wire logic                  ext_bus_disable,
	input  wire logic [1:0]            write_mode_select,
	input  wire logic [1:0]            wait_count,
	input  wire logic                  boot_or_ext_mode,
	input  wire logic                  sleep_mode,
	// Core request
	input  wire logic                  exec_external,
	input  wire logic                  req_valid,
	input  wire logic                  req_is_fetch,
	input  wire logic                  table_write_op,
	input  wire logic [ADDR_W-1:0]     table_pointer,
	input  wire logic [7:0]            table_latch,
	// Answer
	output logic                       req_done,
	output logic [DATA_W-1:0]          read_data,
	output logic                       busy,
	output logic                       bus_active,
	// General port logic
	input  wire logic [27:0]           port_out,
	input  wire logic [27:0]           port_oe,
	// Pins
	input  wire logic [DATA_W-1:0]     ad_in,
	output logic      [27:0]           pin_out,
	output logic      [27:0]           pin_oe
);
	import ext_bus_pkg::*;

	pin_mux_if mux ();

	bus_state_type       state;
	logic [1:0]          wait_left;
	logic                disable_eff;
	logic [7:0]          hold_byte;
	logic [ADDR_W-1:0]   addr;
	logic                is_write;
	logic                is_fetch;
	logic [7:0]          wdata;
	logic [1:0]          wmode;
	logic                bus_own_r;
	logic [DATA_W-1:0]   ad_out;
	logic                ad_oe;
	logic [7:0]          ctl;
	logic                wr_odd;
	logic                end_cyc;
	logic                end_d;
	logic                rd_d;

	////////////////////////////////////////////////////////////////
	// Effective disable: held off while running externally
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			disable_eff <= 1'b0;
		end else if (!exec_external) begin
			disable_eff <= ext_bus_disable;
		end else if (!ext_bus_disable) begin
			disable_eff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus cycle sequencer
	// Width is always 16 bits; nothing here can narrow it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= ST_IDLE;
			wait_left <= 2'h0;
			addr      <= '0;
			is_write  <= 1'b0;
			is_fetch  <= 1'b0;
			wdata     <= 8'h00;
			wmode     <= WM_BYTE_WR;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (req_valid && !sleep_mode) begin
						state    <= ST_ADDR;
						addr     <= table_pointer;
						is_write <= table_write_op && !req_is_fetch;
						is_fetch <= req_is_fetch;
						wdata    <= table_latch;
						wmode    <= write_mode_select;
					end
				end
				ST_ADDR: begin
					state     <= ST_DATA;
					// Fetches take no wait states, tables take the count set by the wait field
					wait_left <= is_fetch ? 2'h0
						: wait_cycles(wait_count);
				end
				ST_DATA: begin
					if (wait_left == 2'h0) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					wait_left <= wait_left - 2'h1;
					if (wait_left == 2'h1) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Word-write holding latch for even addresses
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_byte <= 8'h00;
		end else if (state == ST_ADDR && is_write && wmode[WM_WORD_BIT]
			&& !addr[0]) begin
			hold_byte <= wdata;
		end
	end

	assign wr_odd = addr[0];

	////////////////////////////////////////////////////////////////
	// Pin values for each phase of the cycle
	always_comb begin
		ctl    = CTL_IDLE;
		ad_out = '0;
		ad_oe  = 1'b0; // Float while idle
		unique case (state)
			ST_IDLE: begin
			end
			ST_ADDR: begin
				ad_out       = addr[DATA_W-1:0];
				ad_oe        = 1'b1;
				ctl[CTL_ALE] = 1'b1;
				ctl[CTL_CE]  = 1'b0;
			end
			ST_DATA, ST_WAIT: begin
				ctl[CTL_CE] = 1'b0;
				if (!is_write) begin
					ctl[CTL_OE] = 1'b0; // Both bytes at once
					ctl[CTL_LB] = 1'b0;
					ctl[CTL_UB] = 1'b0;
				end else if (wmode[WM_WORD_BIT]) begin
					ctl[CTL_BA0] = wr_odd;
					ctl[CTL_LB]  = 1'b0;
					ctl[CTL_UB]  = 1'b0;
					if (wr_odd) begin
						ad_out = {wdata, hold_byte};
						ad_oe  = 1'b1;
						ctl[CTL_WRH] = 1'b0;
					end
					// Even address: bus floats, no strobe
				end else if (wmode == WM_BYTE_SEL) begin
					ad_out       = {wdata, wdata};
					ad_oe        = 1'b1;
					ctl[CTL_WRH] = 1'b0;
					ctl[CTL_BA0] = wr_odd;
					ctl[CTL_UB]  = !wr_odd;
					ctl[CTL_LB]  = wr_odd;
				end else begin
					ad_out = {wdata, wdata};
					ad_oe  = 1'b1;
					if (wr_odd) begin
						ctl[CTL_WRH] = 1'b0;
					end else begin
						ctl[CTL_WRL] = 1'b0;
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Bus ownership: any access, or disable cleared in boot/ext mode
	always_comb begin
		bus_own_r = (state != ST_IDLE)
			|| (boot_or_ext_mode && !disable_eff);
	end

	assign mux.bus_own = bus_own_r;
	assign mux.ad_out  = ad_out;
	assign mux.ad_oe   = ad_oe;
	assign mux.a_hi    = (state == ST_IDLE) ? 4'h0
		: addr[ADDR_W-1:DATA_W];
	assign mux.ctl     = sleep_mode ? CTL_IDLE : ctl;

	// Upper address lines float when idle
	ext_pin_mux u_mux (
		.clk      (clk),
		.arst_n   (arst_n),
		.bus      (mux),
		.port_out (port_out),
		.port_oe  (port_oe),
		.pin_out  (pin_out),
		.pin_oe   (pin_oe)
	);

	////////////////////////////////////////////////////////////////
	// Last internal data cycle of the bus cycle
	assign end_cyc = (state == ST_DATA && wait_left == 2'h0)
		|| (state == ST_WAIT && wait_left == 2'h1);

	// Pins lag the sequencer by one register, so the answer waits too
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			end_d <= 1'b0;
			rd_d  <= 1'b0;
		end else begin
			end_d <= end_cyc;
			rd_d  <= end_cyc && !is_write;
		end
	end

	////////////////////////////////////////////////////////////////
	// Answer to the core; data taken while the pins still show OE
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			req_done   <= 1'b0;
			read_data  <= '0;
			busy       <= 1'b0;
			bus_active <= 1'b0;
		end else begin
			req_done <= end_d;
			if (rd_d) begin
				read_data <= ad_in;
			end
			busy       <= (state != ST_IDLE);
			bus_active <= bus_own_r;
		end
	end
endmodule : ext_memory_bus_16bit

/* tb/ext_bus_properties.sv */
module ext_bus_checker
	import ext_bus_pkg::*;
(
	// Clock and reset
	input wire logic		clk,
	input wire logic		arst_n,
	// Request
	input wire logic [1:0]		write_mode_select,
	input wire logic [1:0]		wait_count,
	input wire logic		sleep_mode,
	input wire logic		req_valid,
	input wire logic		req_is_fetch,
	input wire logic		table_write_op,
	input wire logic [ADDR_W-1:0]	table_pointer,
	input wire logic [7:0]		table_latch,
	// Answer and pins
	input wire logic		req_done,
	input wire logic		busy,
	input wire logic		bus_active,
	input wire logic [27:0]		pin_out,
	input wire logic [27:0]		pin_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic			take, wr;
	logic [ADDR_W-1:0]	tp;
	logic [7:0]		tl, held;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// Taken only when idle and awake
	assign take = req_valid && !busy && !sleep_mode;
	assign wr = take && table_write_op;
	// Fields kept for later phases, and the byte parked by an even word write
	always_ff @(posedge clk) begin
		if (take) begin
			tp <= table_pointer;
			tl <= table_latch;
		end
		if (wr && write_mode_select[1] && !table_pointer[0]) begin
			held <= table_latch;
		end
	end
	sequence s_addr;
		pin_out[20] && !pin_out[25] && pin_out[19:0] == tp && &pin_oe[19:0];
	endsequence
	// Data on both bytes with only the high strobe low
	sequence s_high(logic [7:0] lo);
		pin_out[15:0] == {tl, lo} && !pin_out[23] && pin_out[22];
	endsequence
	AST_ADDR_PHASE: assert property (take |-> ##2 s_addr)
		else $error("address phase wrong");
	AST_READ_OE: assert property (
		take && !table_write_op |-> ##3 !pin_out[21] && !pin_out[25])
		else $error("no output enable");
	AST_DONE: assert property (
		take && (req_is_fetch || wait_count == 2'h3) |-> ##4 req_done)
		else $error("done late or early");
	AST_SLEEP_CE: assert property (
		sleep_mode && $past(sleep_mode) && bus_active |-> pin_out[25])
		else $error("chip select in sleep");
	AST_IDLE: assert property (
		(bus_active && !busy) [*3] |->
		pin_oe[19:0] == 20'h0 && pin_out[27:20] == 8'hee)
		else $error("idle pins wrong");
	AST_BYTE_WR: assert property (
		wr && write_mode_select == WM_BYTE_WR |-> ##3
		pin_out[15:0] == {tl, tl} && pin_out[23:22] == {!tp[0], tp[0]})
		else $error("byte write wrong");
	AST_BYTE_SEL: assert property (
		wr && write_mode_select == WM_BYTE_SEL |-> ##3 s_high(tl) ##0
		pin_out[24] == tp[0] && pin_out[27:26] == {!tp[0], tp[0]})
		else $error("byte select wrong");
	AST_WORD_EVEN: assert property (
		wr && write_mode_select[1] && !table_pointer[0] |-> ##3
		pin_oe[15:0] == 16'h0 && pin_out[23:22] == 2'h3)
		else $error("even word write drove bus");
	AST_WORD_ODD: assert property (
		wr && write_mode_select[1] && table_pointer[0] |-> ##3
		s_high(held) ##0 pin_out[24] && pin_out[27:26] == 2'h0)
		else $error("word write wrong");
endmodule : ext_bus_checker

bind ext_memory_bus_16bit ext_bus_checker chk_u (.clk, .arst_n,
	.write_mode_select, .wait_count, .sleep_mode, .req_valid,
	.req_is_fetch, .table_write_op, .table_pointer, .table_latch,
	.req_done, .busy, .bus_active, .pin_out, .pin_oe);

/* tb/ext_mem_model.sv */
module ext_mem_model (
	// Clock
	input wire logic		clk,
	// Pins seen by the memory
	input wire logic [27:0]	pin_out,
	input wire logic [27:0]	pin_oe,
	output logic [15:0]		ad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [19:0]	addr = 20'h0;
	logic [15:0]	last = 16'h0;
	logic		rd;
	////////////////////////////////////////
	// Drives only with chip and output enables low
	assign rd = pin_oe[21] && !pin_out[21] && !pin_out[25];
	// Released bus flips every cycle so a stale word never looks valid
	assign ad_in = rd ? {addr[7:0] ^ 8'h3c, addr[15:8]} : ~last;
	// Address captured while the latch strobe is high
	always @(posedge clk) begin
		if (pin_oe[20] && pin_out[20])
			addr <= pin_out[19:0];
		last <= ad_in;
	end
endmodule : ext_mem_model

/* tb/ext_memory_bus_16bit_tb.sv */
module ext_memory_bus_16bit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clk, arst_n, ext_bus_disable, boot_or_ext_mode, sleep_mode;
	logic		exec_external, req_valid, req_is_fetch, table_write_op;
	logic		req_done, busy, bus_active, saw_bus;
	logic [1:0]	write_mode_select, wait_count;
	logic [19:0]	table_pointer, p;
	logic [7:0]	table_latch;
	logic [15:0]	ad_in, read_data;
	logic [27:0]	port_out, port_oe, pin_out, pin_oe;
	int		n_fail = 0;
	int		num_checks = 0;
	int		seed = 1603;
	int		n;
	ext_memory_bus_16bit dut_u (.clk, .arst_n, .ext_bus_disable,
		.write_mode_select, .wait_count, .boot_or_ext_mode, .sleep_mode,
		.exec_external, .req_valid, .req_is_fetch, .table_write_op,
		.table_pointer, .table_latch, .req_done, .read_data, .busy,
		.bus_active, .port_out, .port_oe, .ad_in, .pin_out, .pin_oe);
	ext_mem_model mem_u (.clk, .pin_out, .pin_oe, .ad_in);
	////////////////////////////////////////
	// 50 MHz clock
	always #10 clk = ~clk;
	// Word the memory returns for an address
	function automatic logic [15:0] exp_word(input logic [19:0] a);
		return {a[7:0] ^ 8'h3c, a[15:8]};
	endfunction : exp_word
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	// One request; cycles counted from the taking edge to done
	task automatic run(input logic f, w, input logic [19:0] a, input int e);
		@(posedge clk);
		table_pointer <= a;
		table_latch <= 8'($random(seed));
		req_is_fetch <= f;
		table_write_op <= w;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		saw_bus = 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
			saw_bus |= bus_active;
		end while (req_done !== 1'b1 && n < 40);
		chk(n == e, "latency");
		if (!w) chk(read_data === exp_word(a), "read data");
		// Next request only once busy has dropped
		while (busy !== 1'b0 && n < 60) begin
			@(posedge clk);
			n++;
		end
	endtask : run
	// Cut a hang: some 5000 cycles, far beyond the roughly 120 needed
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end
	// Main sequence
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{ext_bus_disable, sleep_mode, exec_external, req_valid} = 4'h0;
		{req_is_fetch, table_write_op, write_mode_select} = 4'h0;
		boot_or_ext_mode = 1'b1;
		wait_count = 2'h3;
		table_pointer = 20'h0;
		table_latch = 8'h0;
		port_out = 28'($random(seed));
		port_oe = 28'($random(seed));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			ext_bus_disable <= i[0];
			run(1'b1, 1'b0, 20'($random(seed)), 3);
			chk(saw_bus === 1'b1, "bus not taken");
		end
		$display("end fetch");
		ext_bus_disable <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wait_count <= 2'(i);
			run(1'b0, 1'b0, 20'($random(seed)), 6 - i);
		end
		$display("end table read");
		// Every mode, even then odd within one word
		for (int i = 0; i < 8; i++) begin
			write_mode_select <= 2'(i >> 1);
			if (!i[0])
				p = 20'($random(seed));
			run(1'b0, 1'b1, {p[19:1], i[0]}, 3);
		end
		$display("end write");
		sleep_mode <= 1'b1;
		req_valid <= 1'b1;
		repeat (8) @(posedge clk);
		chk(busy === 1'b0 && pin_out[25] === 1'b1, "sleep");
		req_valid <= 1'b0;
		sleep_mode <= 1'b0;
		$display("end sleep");
		ext_bus_disable <= 1'b1;
		exec_external <= 1'b1;
		repeat (6) @(posedge clk);
		chk(bus_active === 1'b1, "released early");
		exec_external <= 1'b0;
		repeat (6) @(posedge clk);
		chk(!bus_active && pin_oe === port_oe, "io");
		chk(pin_out === port_out, "io value");
		$display("end disable");
		complete_run();
	end
endmodule : ext_memory_bus_16bit_tb
